/* inc/srcp_pkg.sv */
// Purpose: shared constants for the serial register command port
// Assumes: 24-bit frames, msb first, 16-bit registers
// Notes:   timing counts are in cycles of the 40 MHz system clock
package srcp_pkg;
  localparam int FRAME_BITS     = 24;
  localparam int ADDR_BITS      = 7;
  localparam int DATA_BITS      = 16;
  localparam int PTR_BITS       = 8;
  localparam int DIR_POS        = 23;
  localparam int ADDR_MSB       = 22;
  localparam int ADDR_LSB       = 16;
  localparam int DATA_MSB       = 15;
  localparam int CNT_BITS       = 16;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic DIR_WRITE    = 1'b0;
  localparam logic DIR_READ     = 1'b1;
endpackage : srcp_pkg

/* sim/srcp_host.sv */
// Purpose: host spi controller model that sends frames into the command port
// Assumes: gated serial clock idling low, 200 ns period, unrelated to clk
// Notes:   bit count is an argument so short and chained frames can be sent
`timescale 1ns/1ps
module srcp_host (
  output logic      cs_b,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo_out,
  input  wire logic sdo_oe_b
);
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // exact clock burst
  task automatic xfer(input logic [47:0] tx, input int nbits, output logic [47:0] rx);
    rx   = '0;
    #7;
    cs_b = 1'b0;
    #300;
    for (int i = nbits - 1; i >= 0; i--) begin
      sclk = 1'b1;
      sdi  = tx[i];
      #100;
      sclk = 1'b0;
      // sdo stands until the next rise, so sample late in the low half
      #95;
      rx[i] = (sdo_oe_b === 1'b0) ? sdo_out : 1'bz;
      #5;
    end
    #300;
    cs_b = 1'b1;
    // released line shows the inverse so a stale value cannot pass
    sdi  = ~sdi;
    #400;
  endtask : xfer
endmodule : srcp_host

/* sim/tb_top.sv */
// Purpose: self-checking bench for the serial register command port
// Assumes: reg_rdata is a fixed function of reg_addr
// Notes:   commit is checked by counting strobe pulses after each frame
`timescale 1ns/1ps
module tb_top;
  import srcp_pkg::*;
  logic                 clk, rst_b, chain_en, cs_b, sclk, sdi;
  logic                 sdo_out, sdo_oe_b, daisy_mode, reg_wr, reg_rd;
  logic [ADDR_BITS-1:0] reg_addr;
  logic [DATA_BITS-1:0] reg_wdata, reg_rdata;
  logic [PTR_BITS-1:0]  reg_ptr;
  logic [47:0]          rx;
  int                   num_errors = 0, tests_run = 0, wr_seen = 0, rd_seen = 0;

  // distinct read data per address
  assign reg_rdata = {reg_addr, 2'b10, ~reg_addr};

  srcp_port dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .sdi(sdi),
    .sdo_out(sdo_out), .sdo_oe_b(sdo_oe_b), .daisy_mode(daisy_mode), .chain_en(chain_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_ptr(reg_ptr));
  srcp_host host (.cs_b(cs_b), .sclk(sclk), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_b(sdo_oe_b));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (reg_wr === 1'b1) wr_seen++;
    if (reg_rd === 1'b1) rd_seen++;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic frame(input logic [47:0] tx, input int n);
    host.xfer(tx, n, rx);
    repeat (10) @(posedge clk);
  endtask : frame

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_write;
    wr_seen = 0;
    frame({24'h0, 1'b0, 7'h35, 16'ha5c3}, 24);
    chk(24'(wr_seen), 24'h1);
    chk(24'(reg_addr), 24'h35);
    chk(24'(reg_wdata), 24'ha5c3);
    chk(24'(reg_ptr), 24'h35);
    chk(24'(sdo_oe_b), 24'h1);
  endtask : t_write

  task automatic t_read;
    rd_seen = 0;
    wr_seen = 0;
    frame({24'h0, 1'b1, 7'h0a, 16'hffff}, 24);
    frame({24'h0, 1'b1, 7'h21, 16'h0000}, 24);
    chk(24'(rd_seen), 24'h2);
    chk(24'(wr_seen), 24'h0);
    chk(24'(rx[15:0]), 24'h001575);
    chk(24'(reg_ptr), 24'h21);
  endtask : t_read

  task automatic t_bad_count;
    wr_seen = 0;
    frame({25'h0, 7'h10, 16'h1111}, 23);
    frame({24'h0, 1'b0, 7'h12, 16'h2222}, 25);
    chk(24'(wr_seen), 24'h0);
    chk(24'(reg_ptr), 24'h21);
    frame({24'h0, 1'b0, 7'h11, 16'h0f0f}, 24);
    chk(24'(wr_seen), 24'h1);
    chk(24'(reg_wdata), 24'h0f0f);
  endtask : t_bad_count

  task automatic t_chain;
    @(negedge clk) chain_en = 1'b1;
    wr_seen = 0;
    frame({24'h221234, 24'h33beef}, 48);
    chk(rx[23:0], 24'h221234);
    chk(24'(reg_addr), 24'h33);
    chk(24'(reg_wdata), 24'hbeef);
    chk(24'(wr_seen), 24'h1);
    chk(24'(daisy_mode), 24'h1);
    @(negedge clk) chain_en = 1'b0;
  endtask : t_chain

  initial begin
    rst_b    = 1'b0;
    chain_en = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    repeat (4) @(posedge clk);
    t_write();
    t_read();
    t_bad_count();
    t_chain();
    wrap_up();
  end

  // frames take about 6 us per 24 bits; allow a wide margin
  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end
endmodule : tb_top

/* verilog/srcp_port.sv */
// Purpose: spi target command port giving register read and write access
// Assumes: sclk, cs_b and sdi are slow against clk (>= 4 clk per half period)
// Notes:   all pins sampled by clk; sdo changes after the detected sclk rise
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - one access is a 24-bit frame: direction, seven address, sixteen data bits
// - direction 0 writes the sixteen data bits to the addressed register
// - direction 1 reads the addressed register; data bits are ignored
// - frame bits 22 to 16 hold the register address
// - write data bits 15..0 land unchanged in register bits 15..0
// - read data leaves on sdo in the low sixteen bits of the next frame
// - after a write frame the low sixteen sdo bits are undefined
// - chip select falling starts a frame and clears the edge count
// - chip select rising copies the shifter and commits to the register only after exactly 24 falling edges or in chain mode
// - while chip select is low every sclk keeps shifting sdi in
// - beyond 24 clocks older bits ripple out on sdo to the next device
// - sdo changes on sclk rising, valid at the next falling edge
// - chip select rising stops further shifting and commits the shifter if it holds a 24-edge or chained frame
// - registers are 16 bits; an 8-bit pointer selects them, kept after access
// - sdi captured msb first on sclk falling, only while chip select low
// - chip select high blocks sclk and sdi and floats sdo
module srcp_port
  import srcp_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       cs_b,
  input  wire logic                       sclk,
  input  wire logic                       sdi,
  output logic                            sdo_out,
  output logic                            sdo_oe_b,
  output logic                            daisy_mode,
  input  wire logic                       chain_en,
  output logic [srcp_pkg::ADDR_BITS-1:0]  reg_addr,
  output logic [srcp_pkg::DATA_BITS-1:0]  reg_wdata,
  output logic                            reg_wr,
  output logic                            reg_rd,
  input  wire logic [srcp_pkg::DATA_BITS-1:0] reg_rdata,
  output logic [srcp_pkg::PTR_BITS-1:0]   reg_ptr
);
  import srcp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [FRAME_BITS-1:0] shift;
    logic [FRAME_BITS-1:0] in_reg;
    logic [CNT_BITS-1:0]   edges;
    logic                  active;
    logic                  sdo;
    logic                  rd_pend;
    logic [ADDR_BITS-1:0]  addr;
    logic [DATA_BITS-1:0]  wdata;
    logic                  wr;
    logic                  rd;
    logic [PTR_BITS-1:0]   ptr;
    logic                  chain;
  } srcp_st_t;

  srcp_st_t st_ff;
  srcp_st_t nxt_st;

  logic cs_lvl, cs_rise, cs_fall;
  logic sclk_lvl, sclk_rise, sclk_fall;
  logic sdi_lvl;

  srcp_sync #(.RST_VAL(1'b1)) u_cs (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (cs_b),
    .level (cs_lvl),
    .rise  (cs_rise),
    .fall  (cs_fall)
  );

  srcp_sync #(.RST_VAL(1'b0)) u_sclk (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (sclk),
    .level (sclk_lvl),
    .rise  (sclk_rise),
    .fall  (sclk_fall)
  );

  srcp_sync #(.RST_VAL(1'b0)) u_sdi (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (sdi),
    .level (sdi_lvl),
    .rise  (),
    .fall  ()
  );

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.wr = 1'b0;
    nxt_st.rd = 1'b0;
    nxt_st.chain = chain_en;
    if (cs_fall) begin
      nxt_st.active = 1'b1;
      nxt_st.edges  = '0;
    end
    if (st_ff.active && !cs_lvl && sclk_fall) begin
      nxt_st.shift = {st_ff.shift[FRAME_BITS-2:0], sdi_lvl};
      if (st_ff.edges != '1) begin
        nxt_st.edges = st_ff.edges + 1'b1;
      end
    end
    if (st_ff.active && !cs_lvl && sclk_rise) begin
      nxt_st.sdo = st_ff.shift[FRAME_BITS-1];
    end
    if (cs_rise && st_ff.active) begin
      nxt_st.active = 1'b0;
      nxt_st.in_reg = st_ff.shift;
      if (st_ff.chain || st_ff.edges == CNT_BITS'(FRAME_BITS)) begin
        nxt_st.addr = st_ff.shift[ADDR_MSB:ADDR_LSB];
        nxt_st.ptr  = {1'b0, st_ff.shift[ADDR_MSB:ADDR_LSB]};
        if (st_ff.shift[DIR_POS] == DIR_WRITE) begin
          nxt_st.wdata   = st_ff.shift[DATA_MSB:0];
          nxt_st.wr      = 1'b1;
          nxt_st.rd_pend = 1'b0;
        end else begin
          nxt_st.rd      = 1'b1;
          nxt_st.rd_pend = 1'b1;
        end
      end
    end
    // read data preloaded for next frame
    // after a write low bits are stale
    if (st_ff.rd) begin
      nxt_st.shift = {8'h00, reg_rdata};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{shift: '0, in_reg: '0, edges: '0, active: 1'b0, sdo: 1'b0,
                 rd_pend: 1'b0, addr: '0, wdata: '0, wr: 1'b0, rd: 1'b0,
                 ptr: PTR_RST, chain: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // float sdo while deselected
  assign sdo_oe_b   = cs_lvl | ~st_ff.active;
  assign sdo_out    = st_ff.sdo;
  assign daisy_mode = st_ff.chain;
  assign reg_addr   = st_ff.addr;
  assign reg_wdata  = st_ff.wdata;
  assign reg_wr     = st_ff.wr;
  assign reg_rd     = st_ff.rd;
  assign reg_ptr    = st_ff.ptr;

  //////////////////////////////////////////////////////////////////////////
  a_write_strobe_data: assert property (@(posedge clk) disable iff (!rst_b)
    (cs_rise && st_ff.active && !st_ff.chain && st_ff.edges == CNT_BITS'(FRAME_BITS)
     && st_ff.shift[DIR_POS] == DIR_WRITE)
    |=> (reg_wr && reg_wdata == $past(st_ff.shift[DATA_MSB:0])))
    else $error("write frame did not strobe its data");

  a_read_no_write: assert property (@(posedge clk) disable iff (!rst_b)
    (cs_rise && st_ff.active && st_ff.shift[DIR_POS] == DIR_READ) |=> !reg_wr)
    else $error("read frame produced a write");

  a_addr_field: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr || reg_rd) |-> reg_addr == $past(st_ff.shift[ADDR_MSB:ADDR_LSB]))
    else $error("address field mismatch");

  a_read_preload: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd |=> st_ff.shift[DATA_MSB:0] == $past(reg_rdata))
    else $error("read data not loaded for next frame");

  a_count_reset: assert property (@(posedge clk) disable iff (!rst_b)
    cs_fall |=> st_ff.edges == '0)
    else $error("edge count not cleared at frame start");

  a_bad_count: assert property (@(posedge clk) disable iff (!rst_b)
    (cs_rise && !st_ff.chain && st_ff.edges != CNT_BITS'(FRAME_BITS))
    |=> !(reg_wr || reg_rd))
    else $error("frame with wrong edge count committed");

  a_sdo_float: assert property (@(posedge clk) disable iff (!rst_b)
    cs_lvl |-> sdo_oe_b)
    else $error("sdo driven while deselected");

  a_shift_msb: assert property (@(posedge clk) disable iff (!rst_b)
    (st_ff.active && !cs_lvl && sclk_fall && !st_ff.rd)
    |=> st_ff.shift == {$past(st_ff.shift[FRAME_BITS-2:0]), $past(sdi_lvl)})
    else $error("shift register did not take sdi msb first");

  a_sdo_on_rise: assert property (@(posedge clk) disable iff (!rst_b)
    !sclk_rise |=> $stable(st_ff.sdo))
    else $error("sdo changed outside an sclk rise");

  a_stop_shift: assert property (@(posedge clk) disable iff (!rst_b)
    (cs_rise && st_ff.active) |=> !st_ff.active)
    else $error("shifting continued after chip select rise");

  a_ptr_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(reg_wr || reg_rd) |-> $stable(reg_ptr))
    else $error("pointer moved without an access");

  //////////////////////////////////////////////////////////////////////////
  // strobes, commit path, edge count, sdo drive and idle behaviour

  a_wr_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr |=> !reg_wr)
    else $error("write strobe longer than one cycle");

  a_rd_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd |=> !reg_rd)
    else $error("read strobe longer than one cycle");

  a_strobe_excl: assert property (@(posedge clk) disable iff (!rst_b)
    !(reg_wr && reg_rd))
    else $error("read and write strobes together");

  a_ptr_follows: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr || reg_rd) |-> reg_ptr == {1'b0, reg_addr})
    else $error("pointer does not follow the committed address");

  a_idle_shift: assert property (@(posedge clk) disable iff (!rst_b)
    (cs_lvl && !st_ff.rd) |=> $stable(st_ff.shift))
    else $error("shifter moved while deselected");

  a_idle_sdo: assert property (@(posedge clk) disable iff (!rst_b)
    cs_lvl |=> $stable(sdo_out))
    else $error("sdo moved while deselected");

  a_edge_count: assert property (@(posedge clk) disable iff (!rst_b)
    (st_ff.active && !cs_lvl && !cs_fall && sclk_fall && st_ff.edges != '1)
    |=> st_ff.edges == $past(st_ff.edges) + 1)
    else $error("falling edge not counted");

  a_in_reg_copy: assert property (@(posedge clk) disable iff (!rst_b)
    (cs_rise && st_ff.active) |=> st_ff.in_reg == $past(st_ff.shift))
    else $error("input register not loaded at chip select rise");

  a_read_strobe: assert property (@(posedge clk) disable iff (!rst_b)
    (cs_rise && st_ff.active && st_ff.shift[DIR_POS] == DIR_READ
     && (st_ff.chain || st_ff.edges == CNT_BITS'(FRAME_BITS))) |=> reg_rd)
    else $error("good read frame gave no read strobe");

  a_chain_commit: assert property (@(posedge clk) disable iff (!rst_b)
    (cs_rise && st_ff.active && st_ff.chain && st_ff.shift[DIR_POS] == DIR_WRITE)
    |=> reg_wr)
    else $error("chained write frame not committed");

  a_sdo_driven: assert property (@(posedge clk) disable iff (!rst_b)
    (!cs_lvl && st_ff.active) |-> !sdo_oe_b)
    else $error("sdo floating inside a frame");

  a_sdo_msb: assert property (@(posedge clk) disable iff (!rst_b)
    (st_ff.active && !cs_lvl && sclk_rise)
    |=> st_ff.sdo == $past(st_ff.shift[FRAME_BITS-1]))
    else $error("sdo did not take the shifter msb");
endmodule : srcp_port

/* verilog/srcp_sync.sv */
// Purpose: two-flop synchroniser with edge detect on the synchronised value
// Assumes: input is asynchronous to clk
// Notes:   edge detect reads only the second and third flops
`timescale 1ns/1ps
module srcp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } srcp_sync_st_t;

  srcp_sync_st_t st_ff;
  srcp_sync_st_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = pin;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= {RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.sync;
  assign rise  = st_ff.sync & ~st_ff.prev;
  assign fall  = ~st_ff.sync & st_ff.prev;
endmodule : srcp_sync
